// >>> logic/sdcd_consts.svh
`ifndef SDCD_CONSTS_SVH
`define SDCD_CONSTS_SVH

`define SDCD_ADDR_W 24
`define SDCD_LANE_AW 17
`define SDCD_PORT_GEN_BIT 4
`define SDCD_PORT_FLAG_BIT 5
`define SDCD_PORT_ERR_BIT 0

`define SDCD_WB_IRQ_STATUS 8'h00
`define SDCD_WB_IRQ_MASK 8'h04
`define SDCD_WB_CARD_STATUS 8'h08
`define SDCD_IRQ_MASK_RESET 3'h0
`define SDCD_IRQ_PARITY_BIT 0
`define SDCD_IRQ_IO_WRITE_BIT 1
`define SDCD_IRQ_COLLIDE_BIT 2

`define SDCD_CLK_PERIOD_PS 8000
`define SDCD_REFRESH_PERIOD_NS 15600
`define SDCD_REFRESH_BUSY_NS 400
`define SDCD_REFRESH_INTERVAL \
  ((`SDCD_REFRESH_PERIOD_NS * 1000) / `SDCD_CLK_PERIOD_PS)
`define SDCD_REFRESH_BUSY \
  ((`SDCD_REFRESH_BUSY_NS * 1000 + `SDCD_CLK_PERIOD_PS - 1) / \
   `SDCD_CLK_PERIOD_PS)
`endif

// >>> logic/sdcd_pkg.sv
package sdcd_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_ACCESS = 2'b10,
    ST_RESP = 2'b11
  } sdcd_state_t;

  typedef enum logic [1:0] {
    SZ_256K = 2'b00,
    SZ_128K = 2'b01,
    SZ_64K = 2'b10,
    SZ_NONE = 2'b11
  } sdcd_size_t;

  typedef struct packed {
    logic [23:0] addr;
    logic sync;
    logic mem_rd;
    logic mem_wr;
    logic io_in;
    logic io_out;
    logic req16;
    logic [15:0] wdata;
  } sdcd_bus_req_t;

  typedef struct packed {
    logic [15:0] rdata;
    logic data_oe;
    logic rdy;
    logic ack16;
  } sdcd_bus_rsp_t;

  typedef struct packed {
    logic size_select_half;
    logic size_select_quarter;
    logic wait_three_select;
    logic wait_two_select;
    logic wait_one_select;
    logic wait_zero_select;
    logic width_bank_mode_select;
    logic [7:0] port_address_switches;
    logic [7:0] base_address_switches;
  } sdcd_cfg_t;
endpackage

// >>> logic/sdcd_sync.sv
`timescale 1ns/100ps
module sdcd_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      q_o <= '0;
    end else begin
      s1_reg <= d_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      // A bit moves only once stages two and three agree
      q_o <= (s2_reg & ~(s2_reg ^ s3_reg)) | (q_o & (s2_reg ^ s3_reg));
    end
  end
endmodule

// >>> logic/sdcd_mem.sv
`timescale 1ns/100ps
module sdcd_mem #(
  parameter int AW = 17,
  parameter int DW = 9
) (
  input wire logic clk_i,
  input wire logic we_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [DW-1:0] wdata_i,
  output logic [DW-1:0] rdata_o
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[addr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    rdata_o <= mem[addr_i];
  end
endmodule

// >>> logic/sdcd_top.sv
// The address map and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/100ps
`include "sdcd_consts.svh"
module sdcd_top #(
  parameter int REFRESH_INTERVAL = `SDCD_REFRESH_INTERVAL,
  parameter int REFRESH_BUSY = `SDCD_REFRESH_BUSY
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire sdcd_pkg::sdcd_cfg_t cfg_pins_i,
  input wire sdcd_pkg::sdcd_bus_req_t bus_req_i,
  output sdcd_pkg::sdcd_bus_rsp_t bus_rsp_o,
  output logic refresh_active_o,
  output logic irq_o,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  import sdcd_pkg::*;

  sdcd_cfg_t cfg;
  sdcd_size_t size;
  sdcd_state_t state_reg;
  sdcd_state_t state_next;

  logic [8:0] blk_diff;
  logic mem_hit;
  logic io_hit;
  logic wide_ok;
  logic [1:0] wait_count;
  logic [1:0] bank;
  logic start;
  logic cycle_active;

  logic [`SDCD_LANE_AW-1:0] lane_addr_reg;
  logic a0_reg;
  logic wide_reg;
  logic write_reg;
  logic io_reg;
  logic [15:0] wdata_reg;
  logic [1:0] cnt_reg;

  logic [15:0] ref_timer_reg;
  logic ref_due_reg;
  logic [15:0] ref_busy_cnt_reg;
  logic ref_start;

  logic [8:0] even_wdata;
  logic [8:0] odd_wdata;
  logic [8:0] even_rdata;
  logic [8:0] odd_rdata;
  logic even_we;
  logic odd_we;
  logic even_lane;
  logic odd_lane;
  logic even_err;
  logic odd_err;
  logic [7:0] odd_byte;

  logic gen_en_reg;
  logic flag_en_reg;
  logic err_flag_reg;
  logic err_set;
  logic io_write_done;
  logic collide;

  logic [2:0] irq_stat_reg;
  logic [2:0] irq_stat_next;
  logic [2:0] irq_mask_reg;
  logic [2:0] irq_events;
  logic wb_req;
  logic wb_wr;
  logic [31:0] wb_rdata;

  sdcd_sync #(
    .W($bits(sdcd_cfg_t))
  ) u_cfg_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(cfg_pins_i),
    .q_o(cfg)
  );

  always_comb begin
    case ({cfg.size_select_half, cfg.size_select_quarter})
      2'b00: size = SZ_256K;
      2'b10: size = SZ_128K;
      2'b11: size = SZ_64K;
      default: size = SZ_NONE;
    endcase
  end

  // Block starts at base, need not be aligned to its own size
  assign blk_diff = {1'b0, bus_req_i.addr[23:16]} -
                    {1'b0, cfg.base_address_switches};

  always_comb begin
    mem_hit = 1'b0;
    bank = 2'b00;
    if (!blk_diff[8]) begin
      case (size)
        SZ_256K: begin
          mem_hit = (blk_diff[7:2] == 6'h00);
          bank = blk_diff[1:0];
        end
        SZ_128K: begin
          mem_hit = (blk_diff[7:1] == 7'h00);
          bank = {1'b0, blk_diff[0]};
        end
        SZ_64K: begin
          mem_hit = (blk_diff[7:0] == 8'h00);
          bank = 2'b00;
        end
        default: begin
          mem_hit = 1'b0;
          bank = 2'b00;
        end
      endcase
    end
  end

  assign io_hit =
    (bus_req_i.addr[7:0] == cfg.port_address_switches);

  assign wide_ok = cfg.width_bank_mode_select &&
                   (size == SZ_256K || size == SZ_128K);

  always_comb begin
    // Priority only guards sim; the master must set one jumper
    if (cfg.wait_three_select) begin
      wait_count = 2'h3;
    end else if (cfg.wait_two_select) begin
      wait_count = 2'h2;
    end else if (cfg.wait_one_select) begin
      wait_count = 2'h1;
    end else begin
      wait_count = 2'h0;
    end
  end

  assign cycle_active = bus_req_i.mem_rd | bus_req_i.mem_wr |
                        bus_req_i.io_in | bus_req_i.io_out;

  assign start = bus_req_i.sync && (state_reg == ST_IDLE) &&
    (((bus_req_i.mem_rd | bus_req_i.mem_wr) && mem_hit) ||
     ((bus_req_i.io_in | bus_req_i.io_out) && io_hit));

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start) begin
          state_next = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // Refresh in flight simply stretches the wait states
        if (cnt_reg == 2'h0 && ref_busy_cnt_reg == 16'h0000) begin
          state_next = ST_ACCESS;
        end
      end
      ST_ACCESS: begin
        state_next = ST_RESP;
      end
      ST_RESP: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lane_addr_reg <= '0;
      a0_reg <= 1'b0;
      wide_reg <= 1'b0;
      write_reg <= 1'b0;
      io_reg <= 1'b0;
      wdata_reg <= 16'h0000;
    end else if (start) begin
      lane_addr_reg <= {bank, bus_req_i.addr[15:1]};
      a0_reg <= bus_req_i.addr[0];
      io_reg <= !(bus_req_i.mem_rd | bus_req_i.mem_wr);
      write_reg <= bus_req_i.mem_wr | bus_req_i.io_out;
      wide_reg <= bus_req_i.req16 && wide_ok && !bus_req_i.addr[0] &&
                  (bus_req_i.mem_rd | bus_req_i.mem_wr);
      wdata_reg <= bus_req_i.wdata;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= 2'h0;
    end else if (start) begin
      // Wait states apply to memory cycles only
      cnt_reg <= (bus_req_i.mem_rd | bus_req_i.mem_wr) ?
                 wait_count : 2'h0;
    end else if (state_reg == ST_WAIT && cnt_reg != 2'h0) begin
      cnt_reg <= cnt_reg - 2'h1;
    end
  end

  // Refresh only begins from idle so an access never stalls mid-way
  assign ref_start = ref_due_reg && state_reg == ST_IDLE && !start &&
                     ref_busy_cnt_reg == 16'h0000;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ref_timer_reg <= 16'h0000;
      ref_due_reg <= 1'b0;
    end else begin
      if (ref_timer_reg == 16'(REFRESH_INTERVAL - 1)) begin
        ref_timer_reg <= 16'h0000;
        ref_due_reg <= 1'b1;
      end else begin
        ref_timer_reg <= ref_timer_reg + 16'h0001;
        if (ref_start) begin
          ref_due_reg <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ref_busy_cnt_reg <= 16'h0000;
      refresh_active_o <= 1'b0;
    end else begin
      if (ref_start) begin
        ref_busy_cnt_reg <= 16'(REFRESH_BUSY);
        refresh_active_o <= 1'b1;
      end else if (ref_busy_cnt_reg != 16'h0000) begin
        ref_busy_cnt_reg <= ref_busy_cnt_reg - 16'h0001;
        refresh_active_o <= (ref_busy_cnt_reg != 16'h0001);
      end
    end
  end

  assign even_lane = wide_reg || !a0_reg;
  assign odd_lane = wide_reg || a0_reg;
  assign odd_byte = wide_reg ? wdata_reg[15:8] : wdata_reg[7:0];
  assign even_we = state_reg == ST_ACCESS && write_reg && !io_reg &&
                   even_lane;
  assign odd_we = state_reg == ST_ACCESS && write_reg && !io_reg &&
                  odd_lane;
  // Stored bit makes the nine-bit word odd; zero while generation is off
  assign even_wdata = {gen_en_reg & ~^wdata_reg[7:0],
                       wdata_reg[7:0]};
  assign odd_wdata = {gen_en_reg & ~^odd_byte, odd_byte};

  sdcd_mem #(
    .AW(`SDCD_LANE_AW),
    .DW(9)
  ) u_even_lane (
    .clk_i(clk_i),
    .we_i(even_we),
    .addr_i(lane_addr_reg),
    .wdata_i(even_wdata),
    .rdata_o(even_rdata)
  );

  sdcd_mem #(
    .AW(`SDCD_LANE_AW),
    .DW(9)
  ) u_odd_lane (
    .clk_i(clk_i),
    .we_i(odd_we),
    .addr_i(lane_addr_reg),
    .wdata_i(odd_wdata),
    .rdata_o(odd_rdata)
  );

  assign even_err = even_lane && ~^even_rdata;
  assign odd_err = odd_lane && ~^odd_rdata;
  assign err_set = state_reg == ST_RESP && !io_reg && !write_reg &&
                   flag_en_reg && (even_err || odd_err);
  assign io_write_done = state_reg == ST_RESP && io_reg && write_reg;
  assign collide = start && ref_busy_cnt_reg != 16'h0000;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gen_en_reg <= 1'b0;
      flag_en_reg <= 1'b0;
    end else if (io_write_done) begin
      gen_en_reg <= wdata_reg[`SDCD_PORT_GEN_BIT];
      flag_en_reg <= wdata_reg[`SDCD_PORT_FLAG_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      err_flag_reg <= 1'b0;
    end else if (err_set) begin
      err_flag_reg <= 1'b1;
    end else if (!flag_en_reg) begin
      // Writing flag enable low clears and holds the flag
      err_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_rsp_o.rdata <= 16'h0000;
      bus_rsp_o.data_oe <= 1'b0;
      bus_rsp_o.rdy <= 1'b1;
      bus_rsp_o.ack16 <= 1'b0;
    end else if (start) begin
      bus_rsp_o.rdy <= 1'b0;
      bus_rsp_o.data_oe <= 1'b0;
      bus_rsp_o.ack16 <= 1'b0;
    end else if (state_reg == ST_RESP) begin
      bus_rsp_o.rdy <= 1'b1;
      bus_rsp_o.data_oe <= !write_reg;
      bus_rsp_o.ack16 <= wide_reg;
      if (io_reg) begin
        bus_rsp_o.rdata <= {15'h0000, err_flag_reg};
      end else if (wide_reg) begin
        bus_rsp_o.rdata <= {odd_rdata[7:0], even_rdata[7:0]};
      end else if (a0_reg) begin
        bus_rsp_o.rdata <= {8'h00, odd_rdata[7:0]};
      end else begin
        bus_rsp_o.rdata <= {8'h00, even_rdata[7:0]};
      end
    end else if (state_reg == ST_IDLE && !cycle_active) begin
      bus_rsp_o.data_oe <= 1'b0;
      bus_rsp_o.ack16 <= 1'b0;
    end
  end

  assign irq_events = {collide, io_write_done, err_set};
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // Write lands on the ack edge, while the master still holds it
  assign wb_wr = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];

  always_comb begin
    irq_stat_next = irq_stat_reg;
    if (wb_wr && wb_adr_i == `SDCD_WB_IRQ_STATUS) begin
      irq_stat_next = irq_stat_reg & ~wb_dat_i[2:0];
    end
    // A new event beats a same-cycle clear
    irq_stat_next = irq_stat_next | irq_events;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_reg <= 3'h0;
      irq_mask_reg <= `SDCD_IRQ_MASK_RESET;
      irq_o <= 1'b0;
    end else begin
      irq_stat_reg <= irq_stat_next;
      if (wb_wr && wb_adr_i == `SDCD_WB_IRQ_MASK) begin
        irq_mask_reg <= wb_dat_i[2:0];
      end
      irq_o <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  always_comb begin
    case (wb_adr_i)
      `SDCD_WB_IRQ_STATUS: wb_rdata = {29'h0000_0000, irq_stat_reg};
      `SDCD_WB_IRQ_MASK: wb_rdata = {29'h0000_0000, irq_mask_reg};
      `SDCD_WB_CARD_STATUS: wb_rdata = {8'h00, flag_en_reg, gen_en_reg,
        err_flag_reg, cfg.width_bank_mode_select, wait_count, size,
        cfg.port_address_switches, cfg.base_address_switches};
      default: wb_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req) begin
        wb_dat_o <= wb_rdata;
      end
    end
  end
endmodule

// >>> verification/sdcd_assertions.sv
`timescale 1ns/100ps
module sdcd_assertions
  import sdcd_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire sdcd_pkg::sdcd_cfg_t cfg_pins_i,
  input wire sdcd_pkg::sdcd_bus_req_t bus_req_i,
  input wire sdcd_pkg::sdcd_bus_rsp_t bus_rsp_o,
  input wire logic refresh_active_o,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o
);
  sdcd_cfg_t c;
  sdcd_bus_req_t q;
  sdcd_bus_rsp_t r;
  logic [7:0] diff, low_cnt, blocks;
  logic [1:0] w;
  logic mem_hit, io_hit, taken, is_io, ref_seen;
  assign c = cfg_pins_i;
  assign q = bus_req_i;
  assign r = bus_rsp_o;
  assign diff = q.addr[23:16] - c.base_address_switches;
  assign blocks = c.size_select_quarter ? {7'h00, c.size_select_half}
    : (c.size_select_half ? 8'h02 : 8'h04);
  assign w = c.wait_three_select ? 2'h3 : c.wait_two_select ? 2'h2
    : {1'b0, c.wait_one_select};
  assign mem_hit = (q.mem_rd | q.mem_wr) && diff < blocks
    && q.addr[23:16] >= c.base_address_switches;
  assign io_hit = (q.io_in | q.io_out)
    && q.addr[7:0] == c.port_address_switches;
  assign taken = q.sync && r.rdy && (mem_hit || io_hit);
  // Wait length is only exact when no refresh got in the way
  always_ff @(posedge clk_i) begin
    if (rst_i || r.rdy) begin
      low_cnt <= 8'h00;
      ref_seen <= refresh_active_o & ~rst_i;
    end else begin
      low_cnt <= low_cnt + 8'h01;
      ref_seen <= ref_seen | refresh_active_o;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      is_io <= 1'b0;
    end else if (taken) begin
      is_io <= io_hit;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_wait_start: assert property (
    taken |=> !r.rdy) else $error("decoded cycle not stalled");
  a_mem_waits: assert property (
    $rose(r.rdy) && !is_io && !ref_seen |-> low_cnt == {6'h00, w} + 8'h03)
    else $error("memory wait count wrong");
  a_io_waits: assert property (
    $rose(r.rdy) && is_io && !ref_seen |-> low_cnt == 8'h03)
    else $error("port cycle wait count wrong");
  a_foreign_quiet: assert property (
    q.sync && r.rdy && !mem_hit && !io_hit |=> r.rdy)
    else $error("foreign cycle was answered");
  a_wide_ack: assert property (
    $rose(r.rdy) && (q.mem_rd | q.mem_wr) && q.req16 && !q.addr[0]
    && c.width_bank_mode_select && blocks > 8'h01 |-> r.ack16)
    else $error("wide cycle not acknowledged wide");
  a_narrow_only: assert property (
    r.ack16 |-> blocks > 8'h01 && c.width_bank_mode_select)
    else $error("wide acknowledge in byte mode");
  a_port_status: assert property (
    $rose(r.rdy) && is_io && q.io_in |-> r.rdata[15:1] == 15'h0000)
    else $error("port read upper bits not zero");
  a_oe_reads: assert property (
    $rose(r.data_oe) |-> q.mem_rd || q.io_in)
    else $error("data driven on a write");
  a_wb_answer: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("register access not acknowledged");
  a_wb_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("register acknowledge too long");
  c_wide: cover property (taken && q.req16);
  c_port: cover property (taken && io_hit);
  c_collide: cover property (refresh_active_o && !r.rdy);
endmodule

bind sdcd_top sdcd_assertions i_sdcd_assertions (.clk_i(clk_i),
  .rst_i(rst_i), .cfg_pins_i(cfg_pins_i), .bus_req_i(bus_req_i),
  .bus_rsp_o(bus_rsp_o), .refresh_active_o(refresh_active_o),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o));

// >>> verification/sdcd_master.sv
`timescale 1ns/100ps
module sdcd_master
  import sdcd_pkg::*;
(
  input wire logic clk_i,
  input wire sdcd_pkg::sdcd_bus_rsp_t rsp_i,
  output sdcd_pkg::sdcd_bus_req_t req_o
);
  initial req_o = '0;
  // Strobes s: mem_rd, mem_wr, io_in, io_out, req16
  task automatic xfer(input logic [4:0] s, input logic [23:0] a,
    input logic [15:0] d, input logic hit);
    @(posedge clk_i);
    req_o.addr <= a;
    req_o.wdata <= d;
    {req_o.mem_rd, req_o.mem_wr, req_o.io_in, req_o.io_out,
      req_o.req16} <= s;
    req_o.sync <= 1'b1;
    @(posedge clk_i);
    req_o.sync <= 1'b0;
    if (hit) begin
      do @(posedge clk_i); while (rsp_i.rdy !== 1'b1);
    end else begin
      repeat (8) @(posedge clk_i);
    end
    {req_o.mem_rd, req_o.mem_wr, req_o.io_in, req_o.io_out,
      req_o.req16} <= 5'h00;
    // Released data lines must not keep showing the old value
    req_o.wdata <= ~d;
    @(posedge clk_i);
  endtask
endmodule

// >>> verification/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import sdcd_pkg::*;
  logic clk_i, rst_i, irq_o, refresh_active_o, prev_rdy;
  logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [23:0] a;
  logic [15:0] d;
  logic [32:0] e;
  logic [32:0] exp_q[$];
  sdcd_cfg_t cfg;
  sdcd_bus_req_t req;
  sdcd_bus_rsp_t rsp;
  int mismatches, total_checks, cycles, rdy_lows, ref_cycles;
  sdcd_top #(.REFRESH_INTERVAL(40), .REFRESH_BUSY(4)) i_sdcd_top (
    .clk_i, .rst_i, .cfg_pins_i(cfg), .bus_req_i(req), .bus_rsp_o(rsp),
    .refresh_active_o, .irq_o, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o);
  sdcd_master i_sdcd_master (.clk_i, .rsp_i(rsp), .req_o(req));
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Reads note the expected value; the watcher pops it on the answer
  task automatic wb(input logic we, input logic [7:0] ad,
    input logic [31:0] dt);
    if (!we) exp_q.push_back({1'b0, dt});
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= ad;
    wb_dat_i <= dt;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic mem(input logic rd, input logic w, input logic [23:0] ad,
    input logic [15:0] dt);
    if (rd) exp_q.push_back({!w, 16'h0000, w ? dt : {8'h00, dt[7:0]}});
    i_sdcd_master.xfer({rd, !rd, 2'h0, w}, ad, dt, 1'b1);
  endtask
  task automatic io(input logic rd, input logic [15:0] dt);
    if (rd) exp_q.push_back({17'h0_0000, dt});
    i_sdcd_master.xfer({2'h0, rd, !rd, 1'b0}, 24'h00_0098, dt, 1'b1);
  endtask
  // Any wait state during a foreign cycle means it was answered
  task automatic miss(input logic [4:0] s, input logic [23:0] ad);
    int n;
    n = rdy_lows;
    i_sdcd_master.xfer(s, ad, 16'h0000, 1'b0);
    check({31'h0, rsp.rdy}, 32'h0000_0001);
    check(rdy_lows - n, 32'h0000_0000);
  endtask
  always @(posedge clk_i) begin
    prev_rdy <= rsp.rdy;
    if (rsp.rdy !== 1'b1) rdy_lows <= rdy_lows + 1;
    if (refresh_active_o === 1'b1) ref_cycles <= ref_cycles + 1;
    if (!rst_i && rsp.rdy && prev_rdy === 1'b0 && rsp.data_oe) begin
      e = exp_q.pop_front();
      check({16'h0000, rsp.rdata & (e[32] ? 16'h00FF : 16'hFFFF)},
        e[31:0]);
    end
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      e = exp_q.pop_front();
      check(wb_dat_o, e[31:0]);
    end
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      test_done();
    end
  end
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0000_0000;
    cfg = '0;
    cfg.width_bank_mode_select = 1'b1;
    cfg.wait_zero_select = 1'b1;
    cfg.port_address_switches = 8'h98;
    cfg.base_address_switches = 8'h03;
    rst_i = 1'b1;
    void'($urandom(51223));
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    check({28'h000_0000, rsp.rdy, rsp.data_oe, rsp.ack16, irq_o},
      32'h0000_0008);
    wb(1'b0, 8'h04, 32'h0000_0000);
    wb(1'b0, 8'h10, 32'h0000_0000);
    wb(1'b0, 8'h08, 32'h0010_9803);
    io(1'b0, 16'h0030);
    wb(1'b0, 8'h08, 32'h00D0_9803);
    for (int w = 0; w < 4; w++) begin
      {cfg.wait_three_select, cfg.wait_two_select, cfg.wait_one_select,
        cfg.wait_zero_select} <= 4'h1 << w;
      repeat (6) @(posedge clk_i);
      wb(1'b0, 8'h08, 32'h00D0_9803 | (w << 18));
      for (int k = 0; k < 4; k++) begin
        a = {8'h03 + 8'(k), 16'($urandom)};
        d = 16'($urandom);
        mem(1'b0, ~a[0], a, d);
        mem(1'b1, ~a[0], a, d);
      end
    end
    miss(5'h10, 24'h07_0000);
    miss(5'h08, 24'h02_FFFF);
    miss(5'h10, 24'h83_0000);
    miss(5'h04, 24'h00_0099);
    io(1'b0, 16'h0020);
    mem(1'b0, 1'b0, 24'h03_0101, 16'h0003);
    mem(1'b1, 1'b0, 24'h03_0101, 16'h0003);
    io(1'b1, 16'h0001);
    check({31'h0, irq_o}, 32'h0000_0000);
    wb(1'b1, 8'h04, 32'h0000_0001);
    repeat (3) @(posedge clk_i);
    check({31'h0, irq_o}, 32'h0000_0001);
    io(1'b0, 16'h0010);
    io(1'b0, 16'h0030);
    wb(1'b1, 8'h00, 32'h0000_0001);
    repeat (3) @(posedge clk_i);
    check({31'h0, irq_o}, 32'h0000_0000);
    io(1'b1, 16'h0000);
    cfg.size_select_half <= 1'b1;
    repeat (6) @(posedge clk_i);
    mem(1'b0, 1'b1, 24'h04_1234, 16'hBEEF);
    mem(1'b1, 1'b1, 24'h04_1234, 16'hBEEF);
    miss(5'h10, 24'h05_0000);
    cfg.size_select_quarter <= 1'b1;
    cfg.width_bank_mode_select <= 1'b0;
    repeat (6) @(posedge clk_i);
    wb(1'b0, 8'h08, 32'h00CE_9803);
    mem(1'b0, 1'b1, 24'h03_0010, 16'hA55A);
    mem(1'b1, 1'b0, 24'h03_0010, 16'h005A);
    miss(5'h11, 24'h04_0000);
    cfg.size_select_half <= 1'b0;
    repeat (6) @(posedge clk_i);
    miss(5'h10, 24'h03_0000);
    repeat (4) @(posedge clk_i);
    check({31'h0, ref_cycles > 0}, 32'h0000_0001);
    check(exp_q.size(), 32'h0000_0000);
    test_done();
  end
endmodule
